/* logic/gpib_pkg.sv */
// Constants and types for the instrument bus device port
// How it works
// R1: Full three-wire handshake on every sent byte
// R2: Full three-wire handshake on every accepted byte
// R3: Talk only when addressed; serial poll supported
// R4: Own listen address cancels talker state
// R5: Accept data only when addressed to listen
// R6: Own talk address cancels listener state
// R7: Request service via SRQ, clear when serviced
// R8: Remote, local and lockout under controller command
// R9: Parallel poll is never answered
// R10: Universal and selected device clear both honoured
// R11: Group trigger fires when addressed as listener
// R12: Never drives attention or interface clear
// R13: Message bytes are seven-bit ASCII codes
// R14: Address 0 to 30, only own address recognised
// R15: Messages end in LF or CR LF
// R16: Full output queue flags error and clears queue
// R17: Failed query produces no reply
// R18: Poll returns status byte, then request withdrawn
`default_nettype none
package gpib_pkg;
  // ============================================================
  // Timing
  localparam int CLK_NS     = 10;
  localparam int SETTLE_NS  = 500;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_W   = 6;
  localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(SETTLE_CYC - 1);
  // ============================================================
  // Synchroniser bit positions
  localparam int PIN_ATN  = 0;
  localparam int PIN_IFC  = 1;
  localparam int PIN_REN  = 2;
  localparam int PIN_DAV  = 3;
  localparam int PIN_NRFD = 4;
  localparam int PIN_NDAC = 5;
  localparam int PIN_EOI  = 6;
  localparam int PIN_DIO  = 7;
  localparam int SYNC_W   = 15;
  // ============================================================
  // Bus commands and address groups
  localparam logic [4:0] ADDR_MAX = 5'h1e;
  localparam logic [1:0] LAG_PFX  = 2'h1;
  localparam logic [1:0] TAG_PFX  = 2'h2;
  localparam logic [6:0] CMD_GTL  = 7'h01;
  localparam logic [6:0] CMD_SDC  = 7'h04;
  localparam logic [6:0] CMD_GET  = 7'h08;
  localparam logic [6:0] CMD_LLO  = 7'h11;
  localparam logic [6:0] CMD_DCL  = 7'h14;
  localparam logic [6:0] CMD_SPE  = 7'h18;
  localparam logic [6:0] CMD_SPD  = 7'h19;
  localparam logic [6:0] CMD_UNL  = 7'h3f;
  localparam logic [6:0] CMD_UNT  = 7'h5f;
  localparam logic [7:0] CHAR_CR  = 8'h0d;
  localparam logic [7:0] CHAR_LF  = 8'h0a;
  localparam int STB_RQS = 6;
  // ============================================================
  // Output queue
  localparam int FIFO_W = 9;
  localparam int FIFO_D = 32;
  localparam int FIFO_LAST = 8;
  // ============================================================
  // State types
  typedef enum logic [1:0] {SRC_IDLE, SRC_SETTLE, SRC_DAV} src_state_type;
  typedef enum logic [1:0] {ACC_IDLE, ACC_RDY, ACC_HOLD} acc_state_type;
  typedef enum logic [1:0] {TX_DATA, TX_CR, TX_LF} tx_state_type;
endpackage
`default_nettype wire

/* logic/byte_fifo.sv */
// Output queue with registered read data
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      cnt_r;
  logic             out_v_r;
  logic [WIDTH-1:0] out_d_r;
  wire              push = in_valid && in_ready;
  wire              take = (cnt_r != '0) && (!out_v_r || out_ready);
  assign in_ready  = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = out_v_r;
  assign out_data  = out_d_r;
  // ============================================================
  // Storage, no reset so it maps onto RAM
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end
  // ============================================================
  // Pointers and the read register
  always_ff @(posedge sys_clk) begin
    if (!rst_n || flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
      out_v_r  <= 1'b0;
      out_d_r  <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(take);
      cnt_r    <= cnt_r + (AW+1)'(push) - (AW+1)'(take);
      if (take) begin
        out_d_r <= mem[rd_ptr_r];
        out_v_r <= 1'b1;
      end else if (out_ready) begin
        out_v_r <= 1'b0;
      end
    end
  end
endmodule // byte_fifo
`default_nettype wire

/* logic/gpib_device_port.sv */
// Instrument bus device port: handshakes, addressing, poll, remote
`default_nettype none
module gpib_device_port (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       atn_n_in,
  input  wire logic       ifc_n_in,
  input  wire logic       ren_n_in,
  input  wire logic       dav_n_in,
  output logic            dav_n_out,
  output logic            dav_n_oe,
  input  wire logic       nrfd_n_in,
  output logic            nrfd_n_out,
  output logic            nrfd_n_oe,
  input  wire logic       ndac_n_in,
  output logic            ndac_n_out,
  output logic            ndac_n_oe,
  input  wire logic       eoi_n_in,
  output logic            eoi_n_out,
  output logic            eoi_n_oe,
  output logic            srq_n_out,
  output logic            srq_n_oe,
  input  wire logic [7:0] dio_n_in,
  output logic      [7:0] dio_n_out,
  output logic            dio_n_oe,
  input  wire logic [4:0] cfg_addr,
  input  wire logic       cfg_crlf,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready,
  input  wire logic       reply_abort,
  output logic            query_err,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            rx_end,
  input  wire logic       rx_ready,
  input  wire logic [7:0] stb_in,
  input  wire logic       srq_req,
  output logic            is_talker,
  output logic            is_listener,
  output logic            remote,
  output logic            lockout,
  output logic            dev_clear,
  output logic            trigger
);
  import gpib_pkg::*;

  function automatic logic is_cmd(input logic [6:0] c, input logic [6:0] code);
    return c == code;
  endfunction

  // ============================================================
  // Pin synchronisers
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_r <= '1;
      sync2_r <= '1;
    end else begin
      sync1_r <= {dio_n_in, eoi_n_in, ndac_n_in, nrfd_n_in, dav_n_in, ren_n_in, ifc_n_in, atn_n_in};
      sync2_r <= sync1_r;
    end
  end
  // ATN, IFC and REN are inputs only here: no controller logic exists
  wire       atn = !sync2_r[PIN_ATN]; // R12
  wire       ifc = !sync2_r[PIN_IFC]; // R12
  wire       ren = !sync2_r[PIN_REN];
  wire       dav = !sync2_r[PIN_DAV];
  wire       nrfd = !sync2_r[PIN_NRFD];
  wire       ndac = !sync2_r[PIN_NDAC];
  wire       eoi = !sync2_r[PIN_EOI];
  wire [7:0] bus_byte = ~sync2_r[PIN_DIO +: 8];

  // ============================================================
  // Command decode
  logic          lad_r;
  logic          tad_r;
  logic          spe_r;
  acc_state_type acc_r;
  logic          rx_valid_r;
  wire [6:0] cmd      = bus_byte[6:0];
  wire       addr_ok  = cfg_addr <= ADDR_MAX; // R14
  wire       my_la    = addr_ok && cmd == {LAG_PFX, cfg_addr}; // R14
  wire       my_ta    = addr_ok && cmd == {TAG_PFX, cfg_addr}; // R14
  wire       other_ta = cmd[6:5] == TAG_PFX && !my_ta;
  // ============================================================
  // Acceptor handshake
  wire engaged  = atn || lad_r; // R5
  wire can_take = atn || !rx_valid_r;
  wire acc_take = engaged && acc_r == ACC_RDY && can_take && dav; // R2
  wire cmd_take = acc_take && atn;
  wire dat_take = acc_take && !atn; // R5
  assign nrfd_n_out = 1'b0;
  assign ndac_n_out = 1'b0;
  assign nrfd_n_oe  = engaged && !(acc_r == ACC_RDY && can_take); // R2
  assign ndac_n_oe  = engaged && acc_r != ACC_HOLD; // R2
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acc_r <= ACC_IDLE;
    end else begin
      case (acc_r)
        ACC_IDLE: acc_r <= engaged ? ACC_RDY : ACC_IDLE;
        ACC_RDY:  acc_r <= !engaged ? ACC_IDLE : acc_take ? ACC_HOLD : ACC_RDY; // R2
        ACC_HOLD: acc_r <= dav ? ACC_HOLD : ACC_RDY; // R2
        default:  acc_r <= ACC_IDLE;
      endcase
    end
  end
  // Received data; the end flag ignores EOI under ATN, so no parallel poll
  logic [7:0] rx_data_r;
  logic       rx_end_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_valid_r <= 1'b0;
      rx_data_r  <= 8'h00;
      rx_end_r   <= 1'b0;
    end else if (dat_take) begin
      rx_valid_r <= 1'b1;
      rx_data_r  <= {1'b0, bus_byte[6:0]}; // R13
      rx_end_r   <= eoi; // R9
    end else if (rx_ready) begin
      rx_valid_r <= 1'b0;
    end
  end
  assign rx_valid = rx_valid_r;
  assign rx_data  = rx_data_r;
  assign rx_end   = rx_end_r;

  // ============================================================
  // Addressing, remote/local, clear and trigger
  logic remote_r;
  logic lockout_r;
  logic dev_clear_r;
  logic trigger_r;
  wire  do_clear = cmd_take && (is_cmd(cmd, CMD_DCL) || (lad_r && is_cmd(cmd, CMD_SDC))); // R10
  always_ff @(posedge sys_clk) begin
    if (!rst_n || ifc) begin
      lad_r <= 1'b0;
      tad_r <= 1'b0;
      spe_r <= 1'b0;
    end else if (cmd_take) begin
      if (my_la) begin
        lad_r <= 1'b1;
        tad_r <= 1'b0; // R4
      end else if (my_ta) begin
        tad_r <= 1'b1; // R3
        lad_r <= 1'b0; // R6
      end else if (is_cmd(cmd, CMD_UNL)) begin
        lad_r <= 1'b0;
      end else if (is_cmd(cmd, CMD_UNT) || other_ta) begin
        tad_r <= 1'b0;
      end else if (is_cmd(cmd, CMD_SPE)) begin
        spe_r <= 1'b1;
      end else if (is_cmd(cmd, CMD_SPD)) begin
        spe_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !ren) begin
      remote_r  <= 1'b0; // R8
      lockout_r <= 1'b0; // R8
    end else if (cmd_take) begin
      if (my_la) begin
        remote_r <= 1'b1; // R8
      end else if (lad_r && is_cmd(cmd, CMD_GTL)) begin
        remote_r <= 1'b0; // R8
      end
      if (is_cmd(cmd, CMD_LLO)) begin
        lockout_r <= 1'b1; // R8
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dev_clear_r <= 1'b0;
      trigger_r   <= 1'b0;
    end else begin
      dev_clear_r <= do_clear; // R10
      trigger_r   <= cmd_take && lad_r && is_cmd(cmd, CMD_GET); // R11
    end
  end
  assign is_talker   = tad_r;
  assign is_listener = lad_r;
  assign remote      = remote_r;
  assign lockout     = lockout_r;
  assign dev_clear   = dev_clear_r;
  assign trigger     = trigger_r;

  // ============================================================
  // Output queue; overflow discards rather than stalling the bus
  logic               q_valid;
  logic [FIFO_W-1:0]  q_data;
  logic               q_pop;
  logic               query_err_r;
  wire                overflow = tx_valid && !tx_ready; // R16
  wire                flush = overflow || reply_abort || do_clear; // R16 R17 R10
  byte_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_queue (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .flush     (flush),
    .in_valid  (tx_valid),
    .in_data   ({tx_last, 1'b0, tx_data[6:0]}), // R13
    .in_ready  (tx_ready),
    .out_valid (q_valid),
    .out_data  (q_data),
    .out_ready (q_pop)
  );
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      query_err_r <= 1'b0;
    end else begin
      query_err_r <= overflow; // R16
    end
  end
  assign query_err = query_err_r;

  // ============================================================
  // Source handshake and talker
  src_state_type         src_r;
  tx_state_type          tx_r;
  logic [SETTLE_W-1:0]   settle_r;
  logic [7:0]            out_byte_r;
  logic                  out_eoi_r;
  logic                  stb_sent_r;
  logic                  srq_pend_r;
  wire       talk_on  = tad_r && !atn; // R3
  wire [7:0] stb_byte = {stb_in[7:STB_RQS+1], srq_pend_r, stb_in[STB_RQS-1:0]}; // R18
  wire       have     = spe_r ? !stb_sent_r : (tx_r != TX_DATA || q_valid);
  wire [7:0] sel_byte = spe_r ? stb_byte : tx_r == TX_CR ? CHAR_CR : tx_r == TX_LF ? CHAR_LF : q_data[7:0];
  wire       src_go   = src_r == SRC_IDLE && talk_on && have;
  wire       src_done = src_r == SRC_DAV && !atn && !ndac; // R1
  wire       poll_done = src_done && spe_r;
  assign q_pop = src_done && !spe_r && tx_r == TX_DATA;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      src_r    <= SRC_IDLE;
      settle_r <= '0;
    end else begin
      settle_r <= src_go ? SETTLE_LOAD : settle_r - SETTLE_W'(settle_r != '0);
      case (src_r)
        SRC_IDLE:   src_r <= src_go ? SRC_SETTLE : SRC_IDLE;
        SRC_SETTLE: src_r <= atn ? SRC_IDLE : (settle_r == '0 && !nrfd) ? SRC_DAV : SRC_SETTLE; // R1
        SRC_DAV:    src_r <= (atn || !ndac) ? SRC_IDLE : SRC_DAV; // R1
        default:    src_r <= SRC_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      out_byte_r <= 8'h00;
      out_eoi_r  <= 1'b0;
    end else if (src_go) begin
      out_byte_r <= sel_byte;
      out_eoi_r  <= !spe_r && tx_r == TX_LF; // R15
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n || do_clear) begin
      tx_r <= TX_DATA;
    end else if (src_done && !spe_r) begin
      case (tx_r)
        TX_DATA: tx_r <= !q_data[FIFO_LAST] ? TX_DATA : cfg_crlf ? TX_CR : TX_LF; // R15
        TX_CR:   tx_r <= TX_LF; // R15
        TX_LF:   tx_r <= TX_DATA;
        default: tx_r <= TX_DATA;
      endcase
    end
  end
  // A new serial poll needs ATN, so ATN re-arms the status byte
  always_ff @(posedge sys_clk) begin
    if (!rst_n || atn) begin
      stb_sent_r <= 1'b0;
    end else if (poll_done) begin
      stb_sent_r <= 1'b1; // R18
    end
  end
  // A new request in the cycle the poll completes wins over the clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      srq_pend_r <= 1'b0;
    end else if (srq_req) begin
      srq_pend_r <= 1'b1; // R7
    end else if (poll_done) begin
      srq_pend_r <= 1'b0; // R7 R18
    end
  end
  assign dav_n_out = 1'b0;
  assign dav_n_oe  = src_r == SRC_DAV; // R1
  assign dio_n_out = ~out_byte_r;
  assign dio_n_oe  = src_r != SRC_IDLE; // R3
  assign eoi_n_out = 1'b0;
  assign eoi_n_oe  = dio_n_oe && out_eoi_r; // R15
  assign srq_n_out = 1'b0;
  assign srq_n_oe  = srq_pend_r; // R7

  // ============================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_talk_needs_addr:   assert property (dio_n_oe |-> tad_r) else $error("bus driven while not talker"); // R3
  a_talk_cancel:       assert property (cmd_take && my_la |=> !tad_r) else $error("talker kept after MLA"); // R4
  a_listen_cancel:     assert property (cmd_take && my_ta |=> !lad_r) else $error("listener kept after MTA"); // R6
  a_rx_needs_lad:      assert property ($rose(rx_valid) |-> $past(lad_r) && !$past(atn))
                         else $error("data accepted unaddressed"); // R5
  a_dav_after_ready:   assert property ($rose(dav_n_oe) |-> $past(!nrfd) && $past(settle_r == '0))
                         else $error("DAV before ready"); // R1
  a_dav_held:          assert property (dav_n_oe && ndac && !atn |=> dav_n_oe) else $error("DAV dropped early"); // R1
  a_acc_hold:          assert property (!ndac_n_oe && engaged |-> $past(dav) || dav)
                         else $error("NDAC released without DAV"); // R2
  a_srq_withdrawn:     assert property (poll_done && !srq_req |=> !srq_n_oe) else $error("SRQ kept after poll"); // R18
  a_overflow_err:      assert property (overflow |=> query_err ##1 !q_valid) else $error("overflow not flagged"); // R16
  a_abort_no_reply:    assert property (reply_abort |=> ##1 !q_valid) else $error("reply kept after abort"); // R17
  a_bad_addr:          assert property (!addr_ok && cmd_take && !lad_r && !tad_r |=> !lad_r && !tad_r)
                         else $error("invalid address recognised"); // R14
  a_trigger:           assert property (cmd_take && lad_r && is_cmd(cmd, CMD_GET) |=> trigger)
                         else $error("trigger missed"); // R11
  a_universal_clear:   assert property (cmd_take && is_cmd(cmd, CMD_DCL) |=> dev_clear) else $error("DCL missed"); // R10
  a_local_on_ren:      assert property (!ren |=> !remote && !lockout) else $error("remote without REN"); // R8
  a_eoi_on_lf:         assert property (eoi_n_oe |-> out_byte_r == CHAR_LF) else $error("EOI not on LF"); // R15
  c_poll:              cover property (poll_done);
  c_msg_end:           cover property (src_done && out_eoi_r && cfg_crlf);
  c_rx_byte:           cover property (dat_take && eoi);
  c_queue_full:        cover property (overflow);
endmodule // gpib_device_port
`default_nettype wire

/* verification/bus_ctl_model.sv */
// Bus controller model: open-drain line wiring, source and acceptor tasks
`default_nettype none
module bus_ctl_model (
  input  wire logic       sys_clk,
  input  wire logic       dav_n_oe,
  input  wire logic       nrfd_n_oe,
  input  wire logic       ndac_n_oe,
  input  wire logic       eoi_n_oe,
  input  wire logic       dio_n_oe,
  input  wire logic [7:0] dio_n_out,
  output logic            atn_n_in,
  output logic            ifc_n_in,
  output logic            ren_n_in,
  output logic            dav_n_in,
  output logic            nrfd_n_in,
  output logic            ndac_n_in,
  output logic            eoi_n_in,
  output logic      [7:0] dio_n_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Controller drives, high means pulling the line low
  logic       c_atn = 1'h0, c_ren = 1'h0, c_dav = 1'h0, c_nrfd = 1'h0;
  logic       c_ndac = 1'h0, c_eoi = 1'h0, c_den = 1'h0;
  logic [7:0] c_dio = 8'h00;
  // ====================
  // Wired lines
  assign atn_n_in  = ~c_atn;
  assign ifc_n_in  = 1'h1;
  assign ren_n_in  = ~c_ren;
  assign dav_n_in  = ~(c_dav | dav_n_oe);
  assign nrfd_n_in = ~(c_nrfd | nrfd_n_oe);
  assign ndac_n_in = ~(c_ndac | ndac_n_oe);
  assign eoi_n_in  = ~(c_eoi | eoi_n_oe);
  // Released data lines float to the termination level, never hold old data
  assign dio_n_in  = (c_den ? ~c_dio : 8'hff) & (dio_n_oe ? dio_n_out : 8'hff);
  // ====================
  // Handshake tasks
  function automatic logic line(input int k);
    return k == 0 ? nrfd_n_in : (k == 1 ? ndac_n_in : dav_n_in);
  endfunction
  task automatic wt(input int k, input logic v, inout bit ok);
    int n;
    n = 0;
    while (line(k) !== v && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 300) ok = 1'h0;
  endtask
  task automatic lines(input logic atn, input logic ren, input logic eoi);
    c_atn <= atn;
    c_ren <= ren;
    c_eoi <= eoi;
    @(posedge sys_clk);
  endtask
  // Source: data settles for dly cycles before DAV, held until all accepted
  task automatic send(input logic [7:0] b, input logic atn, input logic eoi, input int dly, output bit ok);
    ok = 1'h1;
    c_nrfd <= 1'h0;
    c_ndac <= 1'h0;
    c_atn  <= atn;
    c_dio  <= b;
    c_den  <= 1'h1;
    c_eoi  <= eoi;
    repeat (dly) @(posedge sys_clk);
    wt(0, 1'h1, ok);
    c_dav <= 1'h1;
    @(posedge sys_clk);
    wt(1, 1'h1, ok);
    c_dav <= 1'h0;
    c_den <= 1'h0;
    c_eoi <= 1'h0;
    @(posedge sys_clk);
  endtask
  // Acceptor: stalls dly cycles before ready and again before accepting
  task automatic recv(input int dly, output logic [7:0] b, output logic e, output bit ok);
    ok = 1'h1;
    c_atn  <= 1'h0;
    c_nrfd <= 1'h1;
    c_ndac <= 1'h1;
    repeat (dly) @(posedge sys_clk);
    c_nrfd <= 1'h0;
    @(posedge sys_clk);
    wt(2, 1'h0, ok);
    c_nrfd <= 1'h1;
    b = ~dio_n_in;
    e = ~eoi_n_in;
    repeat (dly) @(posedge sys_clk);
    c_ndac <= 1'h0;
    @(posedge sys_clk);
    wt(2, 1'h1, ok);
    c_ndac <= 1'h1;
    @(posedge sys_clk);
  endtask
endmodule  // bus_ctl_model
`default_nettype wire

/* verification/instrument_bus_device_port_bench.sv */
// Self-checking bench for the instrument bus device port
`default_nettype none
module instrument_bus_device_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import gpib_pkg::*;
  logic       sys_clk = 1'h0, rst_n = 1'h0, cfg_crlf = 1'h0, tx_valid = 1'h0, tx_last = 1'h0;
  logic       reply_abort = 1'h0, rx_ready = 1'h0, srq_req = 1'h0;
  logic [7:0] tx_data = 8'h00, stb_in = 8'h00, dio_n_out, rx_data;
  logic [4:0] cfg_addr = 5'h00;
  wire logic  atn_n_in, ifc_n_in, ren_n_in, dav_n_in, nrfd_n_in, ndac_n_in, eoi_n_in;
  wire logic [7:0] dio_n_in;
  logic       dav_n_out, dav_n_oe, nrfd_n_out, nrfd_n_oe, ndac_n_out, ndac_n_oe, eoi_n_out, eoi_n_oe;
  logic       srq_n_out, srq_n_oe, dio_n_oe, tx_ready, query_err, rx_valid, rx_end;
  logic       is_talker, is_listener, remote, lockout, dev_clear, trigger;
  logic [8:0] rxq[$];
  int         n_fail = 0, compares = 0, n_trig = 0, n_clr = 0, n_qerr = 0;
  bit         ok, pp_seen;
  gpib_device_port DUT (
    .sys_clk, .rst_n, .atn_n_in, .ifc_n_in, .ren_n_in, .dav_n_in, .dav_n_out, .dav_n_oe,
    .nrfd_n_in, .nrfd_n_out, .nrfd_n_oe, .ndac_n_in, .ndac_n_out, .ndac_n_oe, .eoi_n_in,
    .eoi_n_out, .eoi_n_oe, .srq_n_out, .srq_n_oe, .dio_n_in, .dio_n_out, .dio_n_oe, .cfg_addr,
    .cfg_crlf, .tx_valid, .tx_data, .tx_last, .tx_ready, .reply_abort, .query_err, .rx_valid,
    .rx_data, .rx_end, .rx_ready, .stb_in, .srq_req, .is_talker, .is_listener, .remote,
    .lockout, .dev_clear, .trigger
  );
  bus_ctl_model ctl (
    .sys_clk, .dav_n_oe, .nrfd_n_oe, .ndac_n_oe, .eoi_n_oe, .dio_n_oe, .dio_n_out,
    .atn_n_in, .ifc_n_in, .ren_n_in, .dav_n_in, .nrfd_n_in, .ndac_n_in, .eoi_n_in, .dio_n_in
  );
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // ====================
  // Monitors: random receive back-pressure, pulse counters
  always @(posedge sys_clk) begin
    rx_ready <= ($urandom % 4) != 0;
    if (rx_valid === 1'h1 && rx_ready === 1'h1) begin
      rxq.push_back({rx_end, rx_data});
    end
    n_trig += int'(trigger === 1'h1);
    n_clr  += int'(dev_clear === 1'h1);
    n_qerr += int'(query_err === 1'h1);
    if (dio_n_oe === 1'h1 && atn_n_in === 1'h0 && eoi_n_in === 1'h0) begin
      pp_seen = 1'h1;
    end
  end
  // ====================
  // Checking and bus helpers
  function automatic logic [6:0] addr_cmd(input logic [1:0] pfx, input int a);
    return {pfx, 5'(a)};
  endfunction
  function automatic logic [8:0] stb_exp(input logic [7:0] s);
    return {1'h0, s[7], 1'h1, s[5:0]};
  endfunction
  task automatic report_and_stop();
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic need();
    if (!ok) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic cmd(input logic [6:0] c);
    ctl.send({1'h0, c}, 1'h1, 1'h0, 4 + $urandom % 8, ok);
    need();
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic get(output logic [8:0] v);
    logic [7:0] b;
    logic       e;
    ctl.recv(1 + $urandom % 40, b, e, ok);
    need();
    v = {e, b};
  endtask
  task automatic push(input int n, output logic [7:0] m[$]);
    m = {};
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      m.push_back(8'($urandom));
      tx_valid <= 1'h1;
      tx_data  <= m[i];
      tx_last  <= 1'(i == n - 1);
      for (int k = 0; k < 100; k++) begin
        @(posedge sys_clk);
        if (tx_ready === 1'h1) break;
      end
      ok = tx_ready === 1'h1;
      tx_valid <= 1'h0;
      need();
    end
  endtask
  task automatic read_msg(input logic [7:0] m[$]);
    logic [8:0] v;
    foreach (m[i]) begin
      get(v);
      chk(v, {1'h0, m[i] & 8'h7f});
    end
    if (cfg_crlf) begin
      get(v);
      chk(v, {1'h0, CHAR_CR});
    end
    get(v);
    chk(v, {1'h1, CHAR_LF});
  endtask
  // ====================
  // Main sequence: two passes, top address with LF, random address with CR LF
  initial begin
    logic [7:0] m[$];
    logic [8:0] v;
    int         a, n, e_t, e_c, e_q;
    void'($urandom(85));
    e_t = 0;
    e_c = 0;
    e_q = 0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    chk({dav_n_oe, nrfd_n_oe, ndac_n_oe, eoi_n_oe, srq_n_oe, dio_n_oe, is_talker, is_listener}, 0);
    chk({dio_n_out, dav_n_out, nrfd_n_out, ndac_n_out, eoi_n_out, srq_n_out}, {8'hff, 5'h00});
    for (int p = 0; p < 2; p++) begin
      a = (p == 0) ? 30 : $urandom % 30;
      cfg_addr <= 5'(a);
      cfg_crlf <= 1'(p);
      ctl.lines(1'h1, 1'h1, 1'h0);
      cmd(CMD_UNL);
      cmd(addr_cmd(LAG_PFX, (a + 1) % 31));
      chk(is_listener, 1'h0);
      ctl.send(8'h41, 1'h0, 1'h0, 4, ok);
      need();
      cmd(addr_cmd(LAG_PFX, a));
      chk({is_listener, remote, rxq.size() == 0}, 3'h7);
      n = 1 + $urandom % 4;
      m = {};
      for (int i = 0; i < n; i++) begin
        m.push_back(8'($urandom % 128));
        ctl.send(m[i], 1'h0, 1'(i == n - 1), 4 + $urandom % 8, ok);
        need();
      end
      for (int k = 0; k < 50 && rxq.size() < n; k++) @(posedge sys_clk);
      foreach (m[i]) chk(rxq.pop_front(), {1'(i == n - 1), m[i]});
      cmd(CMD_GET);
      cmd(CMD_SDC);
      cmd(CMD_DCL);
      cmd(CMD_LLO);
      e_t += 1;
      e_c += 2;
      chk({16'(n_trig), 16'(n_clr), lockout}, {16'(e_t), 16'(e_c), 1'h1});
      cmd(CMD_GTL);
      chk(remote, 1'h0);
      cmd(addr_cmd(TAG_PFX, a));
      chk({is_talker, is_listener}, 2'h2);
      cmd(addr_cmd(LAG_PFX, a));
      chk({is_talker, is_listener}, 2'h1);
      cmd(CMD_UNL);
      cmd(CMD_GET);
      cmd(CMD_SDC);
      chk({n_trig, n_clr}, {e_t, e_c});
      push(1 + $urandom % 6, m);
      cmd(addr_cmd(TAG_PFX, a));
      read_msg(m);
      cmd(CMD_UNT);
      // Service request, then serial poll reads it and withdraws it
      srq_req <= 1'h1;
      stb_in  <= 8'($urandom);
      @(posedge sys_clk);
      srq_req <= 1'h0;
      repeat (2) @(posedge sys_clk);
      chk(srq_n_oe, 1'h1);
      cmd(CMD_SPE);
      cmd(addr_cmd(TAG_PFX, a));
      get(v);
      chk(v, stb_exp(stb_in));
      cmd(CMD_SPD);
      cmd(CMD_UNT);
      chk(srq_n_oe, 1'h0);
      // Parallel poll attempt must find the data lines untouched
      ctl.lines(1'h1, 1'h1, 1'h1);
      repeat (10) @(posedge sys_clk);
      ctl.lines(1'h1, 1'h1, 1'h0);
      // Fill the queue until refused, then one push too many
      n = 0;
      tx_valid <= 1'h1;
      tx_last  <= 1'h0;
      do begin
        tx_data <= 8'($urandom);
        @(posedge sys_clk);
        n += int'(tx_ready === 1'h1);
      end while (tx_ready === 1'h1 && n < 40);
      tx_valid <= 1'h0;
      repeat (3) @(posedge sys_clk);
      e_q += 1;
      chk({16'(n), 16'(n_qerr), tx_ready}, {16'(FIFO_D + 1), 16'(e_q), 1'h1});
      push(3, m);
      reply_abort <= 1'h1;
      @(posedge sys_clk);
      reply_abort <= 1'h0;
      push(1 + $urandom % 4, m);
      cmd(addr_cmd(TAG_PFX, a));
      read_msg(m);
      cmd(CMD_UNT);
      cmd(addr_cmd(LAG_PFX, a));
      chk({remote, lockout}, 2'h3);
      ctl.lines(1'h1, 1'h0, 1'h0);
      repeat (4) @(posedge sys_clk);
      chk({remote, lockout}, 2'h0);
    end
    // Address 31 overlaps the unlisten and untalk codes, so it must never match
    cfg_addr <= 5'h1f;
    cmd(CMD_UNL);
    cmd(CMD_UNT);
    chk({is_talker, is_listener}, 2'h0);
    chk(pp_seen, 1'h0);
    report_and_stop();
  end
endmodule  // instrument_bus_device_port_bench
`default_nettype wire
